// [rtl/cad_defines.vh]
// Constants for the channel activity scan and event pin block
`ifndef CAD_DEFINES_VH
`define CAD_DEFINES_VH

// ==========================================================
// Register byte offsets
`define CAD_OFF_MODE     8'h00
`define CAD_OFF_CFG      8'h04
`define CAD_OFF_PIN_A    8'h08
`define CAD_OFF_PIN_B    8'h0c
`define CAD_OFF_EVENT    8'h10
`define CAD_OFF_MODEM    8'h14
`define CAD_OFF_IRQ_STAT 8'h18
`define CAD_OFF_IRQ_MASK 8'h1c
`define CAD_OFF_SCAN     8'h20

// ==========================================================
// Operating modes
`define CAD_MODE_STBY    3'h0
`define CAD_MODE_RXSGL   3'h1
`define CAD_MODE_RX_CONT 3'h2
`define CAD_MODE_SCAN    3'h3

// ==========================================================
// Event flag bit positions
`define CAD_EV_RXTO      7
`define CAD_EV_RECEIVE_FINISHED    6
`define CAD_EV_CRC       5
`define CAD_EV_HDR       4
`define CAD_EV_TRANSMIT_FINISHED    3
`define CAD_EV_DONE      2
`define CAD_EV_HOP       1
`define CAD_EV_FOUND     0

// ==========================================================
// Modem state bit positions
`define CAD_MS_DET       0
`define CAD_MS_SYNC      1
`define CAD_MS_HDR       3

// ==========================================================
// Configuration fields and reset values
`define CAD_CFG_SF_LSB   0
`define CAD_CFG_BW_LSB   8
`define CAD_SF_RST       4'h7
`define CAD_BW_DIV_RST   16'h03e8
`define CAD_SF_MIN       4'h6
`define CAD_SF_MAX       4'hc

// ==========================================================
// Scan timing in chips
`define CAD_PRE_EXTRA    13'h0020
`define CAD_CORR_MARGIN  13'h0008

`endif

// [rtl/cad_pinmux.v]
// Multipurpose pin function selection
`timescale 1ns/10ps
module cad_pinmux (
    // Pin function selects, two bits per pin
    input  wire [11:0] sel_i,
    // Per-code source vectors, pin 5 in the top bit
    input  wire [5:0]  map00_i,
    input  wire [5:0]  map01_i,
    input  wire [5:0]  map10_i,
    // Pin levels
    output wire [5:0]  pin_o
);

genvar g;
generate
    for (g = 0; g < 6; g = g + 1) begin : g_pin
        reg lvl;
        always @* begin
            case (sel_i[2*g+1:2*g])
                2'h0:    lvl = map00_i[g];
                2'h1:    lvl = map01_i[g];
                2'h2:    lvl = map10_i[g];
                default: lvl = 1'b0;
            endcase
        end
        assign pin_o[g] = lvl;
    end
endgenerate

endmodule // cad_pinmux

// [rtl/cad_seq.v]
// Channel activity scan sequencer
`timescale 1ns/10ps
`include "cad_defines.vh"
module cad_seq (
    // Clock and reset
    input  wire        ref_clk_i,
    input  wire        rst_b_i,
    // Control
    input  wire        start_i,
    input  wire        abort_i,
    input  wire [3:0]  sf_i,
    input  wire [15:0] bw_div_i,
    // Radio side
    input  wire        synth_lock_i,
    input  wire        corr_hit_i,
    output wire        synth_en_o,
    output wire        rx_en_o,
    output wire        corr_run_o,
    // Result
    output wire        done_o,
    output wire        found_o,
    output wire [2:0]  phase_o
);

localparam S_IDLE = 3'h0;
localparam S_LOCK = 3'h1;
localparam S_CAPT = 3'h2;
localparam S_CORR = 3'h3;
localparam S_DONE = 3'h4;

reg [2:0]  state;
reg [2:0]  next_state;
reg [15:0] div_cnt;
reg [12:0] chip_cnt;
reg        hit;
wire [3:0] sf_c;
wire [12:0] sym;
wire       chip_en;
wire       last;

// Clamp keeps the chip counter within 13 bits
assign sf_c = (sf_i < `CAD_SF_MIN) ? `CAD_SF_MIN :
              (sf_i > `CAD_SF_MAX) ? `CAD_SF_MAX : sf_i;
assign sym  = 13'h0001 << sf_c;
// Chip rate is an enable from the bandwidth divider
assign chip_en = (div_cnt + 16'h0001 >= bw_div_i);
assign last = chip_en &&
    (((state == S_CAPT) &&
      (chip_cnt == sym + `CAD_PRE_EXTRA - 13'h0001)) ||
     ((state == S_CORR) &&
      (chip_cnt == sym - `CAD_CORR_MARGIN - 13'h0001)));

always @* begin
    next_state = state;
    case (state)
        S_IDLE: if (start_i) next_state = S_LOCK;
        S_LOCK: if (synth_lock_i) next_state = S_CAPT;
        S_CAPT: if (last) next_state = S_CORR;
        S_CORR: if (last) next_state = S_DONE;
        default: next_state = S_IDLE;
    endcase
    if (abort_i && state != S_DONE)
        next_state = S_IDLE;
end

always @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
        state    <= S_IDLE;
        div_cnt  <= 16'h0000;
        chip_cnt <= 13'h0000;
        hit      <= 1'b0;
    end else begin
        state <= next_state;
        if (next_state != state || chip_en)
            div_cnt <= 16'h0000;
        else
            div_cnt <= div_cnt + 16'h0001;
        if (next_state != state)
            chip_cnt <= 13'h0000;
        else if (chip_en)
            chip_cnt <= chip_cnt + 13'h0001;
        if (state == S_CORR && last)
            hit <= corr_hit_i;
    end
end

assign synth_en_o = (state == S_LOCK) || (state == S_CAPT);
assign rx_en_o    = (state == S_CAPT);
assign corr_run_o = (state == S_CORR);
assign done_o     = (state == S_DONE);
assign found_o    = (state == S_DONE) && hit;
assign phase_o    = state;

endmodule // cad_seq

// [rtl/cad_top.v]
// Channel activity scan, event flags, pin mapping and register slave
//
// The implementer's own choices: the Avalon-MM slave port and the address map.
`timescale 1ns/10ps
`include "cad_defines.vh"
module cad_top (
    // Clock and reset
    input  wire        ref_clk_i,
    input  wire        rst_b_i,
    // Avalon-MM slave
    input  wire [7:0]  avs_address_i,
    input  wire        avs_read_i,
    input  wire        avs_write_i,
    input  wire [31:0] avs_writedata_i,
    output reg  [31:0] avs_readdata_o,
    output wire        avs_waitrequest_o,
    // Radio control
    input  wire        synth_lock_i,
    input  wire        corr_hit_i,
    output wire        synth_en_o,
    output wire        rx_en_o,
    output wire        corr_run_o,
    output wire [2:0]  op_mode_o,
    // Event pulses from the modem
    input  wire        rx_done_i,
    input  wire        rx_timeout_i,
    input  wire        crc_fail_i,
    input  wire        header_ok_i,
    input  wire        tx_done_i,
    input  wire        hop_req_i,
    // Modem levels
    input  wire        mode_settled_i,
    input  wire        clock_output_i,
    input  wire        preamble_seen_i,
    input  wire        demod_lock_i,
    // Multipurpose pins and interrupt
    output reg  [5:0]  mpin_o,
    output wire        irq_o
);

// ==========================================================
// Registers
reg [2:0]  op_mode;
reg [3:0]  sf;
reg [15:0] bw_div;
reg [7:0]  pin_sel_a;
reg [3:0]  pin_sel_b;
reg [7:0]  event_flags;
reg [7:0]  irq_stat;
reg [7:0]  irq_mask;
reg        det_q;
reg        sync_q;
reg        hdr_q;
reg        ack;

// ==========================================================
// Next values
reg [7:0]  next_event;
reg [7:0]  next_irq;
reg [2:0]  next_mode;
reg [31:0] next_rdata;

wire       bus_req;
wire       wr_en;
wire       rd_en;
wire       seq_done;
wire       seq_found;
wire [2:0] seq_phase;
wire [7:0] ev_set;
wire [3:0] modem_state_bits;
wire [5:0] map00;
wire [5:0] map01;
wire [5:0] map10;
wire [5:0] pin_lvl;
wire       start_scan;

// ==========================================================
// Bus handshake
// One wait state gives time to register read data
assign bus_req = avs_read_i | avs_write_i;
assign avs_waitrequest_o = bus_req & ~ack;
assign wr_en = avs_write_i & ack;
assign rd_en = avs_read_i & ack;

always @(posedge ref_clk_i) begin
    if (!rst_b_i)
        ack <= 1'b0;
    else
        ack <= bus_req & ~ack;
end

// ==========================================================
// Scan sequencer
// A scan starts on the write that selects scan mode from any other mode
assign start_scan = wr_en
    && (avs_address_i == `CAD_OFF_MODE)
    && (avs_writedata_i[2:0] == `CAD_MODE_SCAN)
    && (op_mode != `CAD_MODE_SCAN);

// Abort on the same edge as the mode write: no radio cycle outside a scan
cad_seq u_seq (
    .ref_clk_i    (ref_clk_i),
    .rst_b_i      (rst_b_i),
    .start_i      (start_scan),
    .abort_i      (next_mode != `CAD_MODE_SCAN),
    .sf_i         (sf),
    .bw_div_i     (bw_div),
    .synth_lock_i (synth_lock_i),
    .corr_hit_i   (corr_hit_i),
    .synth_en_o   (synth_en_o),
    .rx_en_o      (rx_en_o),
    .corr_run_o   (corr_run_o),
    .done_o       (seq_done),
    .found_o      (seq_found),
    .phase_o      (seq_phase)
);

// ==========================================================
// Operating mode
always @* begin
    next_mode = op_mode;
    if (wr_en && avs_address_i == `CAD_OFF_MODE)
        next_mode = avs_writedata_i[2:0];
    if (seq_done && op_mode == `CAD_MODE_SCAN)
        next_mode = `CAD_MODE_STBY;
end

assign op_mode_o = op_mode;

// ==========================================================
// Event flags
assign ev_set[`CAD_EV_RXTO]   = rx_timeout_i;
assign ev_set[`CAD_EV_RECEIVE_FINISHED] = rx_done_i;
assign ev_set[`CAD_EV_CRC]    = crc_fail_i;
assign ev_set[`CAD_EV_HDR]    = header_ok_i;
assign ev_set[`CAD_EV_TRANSMIT_FINISHED] = tx_done_i;
assign ev_set[`CAD_EV_DONE]   = seq_done;
assign ev_set[`CAD_EV_HOP]    = hop_req_i;
assign ev_set[`CAD_EV_FOUND]  = seq_found;

// Host clears with a one per bit; a new event wins
always @* begin
    next_event = event_flags;
    if (wr_en && avs_address_i == `CAD_OFF_EVENT)
        next_event = event_flags & ~avs_writedata_i[7:0];
    next_event = next_event | ev_set;
end

// Interrupt status clears on read, setting wins
always @* begin
    next_irq = irq_stat;
    if (rd_en && avs_address_i == `CAD_OFF_IRQ_STAT)
        next_irq = 8'h00;
    next_irq = next_irq | ev_set;
end

assign irq_o = |(irq_stat & irq_mask);

// ==========================================================
// Modem state bits
assign modem_state_bits[`CAD_MS_DET]  = det_q;
assign modem_state_bits[`CAD_MS_SYNC] = sync_q;
assign modem_state_bits[2]            = 1'b0;
assign modem_state_bits[`CAD_MS_HDR]  = hdr_q;

// ==========================================================
// Register update
always @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
        op_mode     <= `CAD_MODE_STBY;
        sf          <= `CAD_SF_RST;
        bw_div      <= `CAD_BW_DIV_RST;
        pin_sel_a   <= 8'h00;
        pin_sel_b   <= 4'h0;
        event_flags <= 8'h00;
        irq_stat    <= 8'h00;
        irq_mask    <= 8'h00;
        det_q       <= 1'b0;
        sync_q      <= 1'b0;
        hdr_q       <= 1'b0;
    end else begin
        op_mode     <= next_mode;
        event_flags <= next_event;
        irq_stat    <= next_irq;
        det_q       <= preamble_seen_i;
        sync_q      <= preamble_seen_i & demod_lock_i;
        // Header bit holds until the preamble is lost
        if (header_ok_i)
            hdr_q <= 1'b1;
        else if (!preamble_seen_i)
            hdr_q <= 1'b0;
        if (wr_en) begin
            if (avs_address_i == `CAD_OFF_CFG) begin
                sf     <= avs_writedata_i[`CAD_CFG_SF_LSB+3:
                                          `CAD_CFG_SF_LSB];
                bw_div <= avs_writedata_i[`CAD_CFG_BW_LSB+15:
                                          `CAD_CFG_BW_LSB];
            end else if (avs_address_i == `CAD_OFF_PIN_A) begin
                pin_sel_a <= avs_writedata_i[7:0];
            end else if (avs_address_i == `CAD_OFF_PIN_B) begin
                pin_sel_b <= avs_writedata_i[3:0];
            end else if (avs_address_i == `CAD_OFF_IRQ_MASK) begin
                irq_mask <= avs_writedata_i[7:0];
            end
        end
    end
end

// ==========================================================
// Read data
// Loaded on the first cycle so it stands when waitrequest drops
always @* begin
    next_rdata = 32'h0000_0000;
    if (avs_address_i == `CAD_OFF_MODE)
        next_rdata[2:0] = op_mode;
    else if (avs_address_i == `CAD_OFF_CFG) begin
        next_rdata[`CAD_CFG_SF_LSB+3:`CAD_CFG_SF_LSB] = sf;
        next_rdata[`CAD_CFG_BW_LSB+15:`CAD_CFG_BW_LSB] = bw_div;
    end else if (avs_address_i == `CAD_OFF_PIN_A)
        next_rdata[7:0] = pin_sel_a;
    else if (avs_address_i == `CAD_OFF_PIN_B)
        next_rdata[3:0] = pin_sel_b;
    else if (avs_address_i == `CAD_OFF_EVENT)
        next_rdata[7:0] = event_flags;
    else if (avs_address_i == `CAD_OFF_MODEM)
        next_rdata[3:0] = modem_state_bits;
    else if (avs_address_i == `CAD_OFF_IRQ_STAT)
        next_rdata[7:0] = irq_stat;
    else if (avs_address_i == `CAD_OFF_IRQ_MASK)
        next_rdata[7:0] = irq_mask;
    else if (avs_address_i == `CAD_OFF_SCAN)
        next_rdata[2:0] = seq_phase;
end

always @(posedge ref_clk_i) begin
    if (!rst_b_i)
        avs_readdata_o <= 32'h0000_0000;
    else if (avs_read_i && !ack)
        avs_readdata_o <= next_rdata;
end

// ==========================================================
// Multipurpose pins
// Pins 0 to 3 follow the pending flags, so a host clear drops them
assign map00 = {mode_settled_i,
                event_flags[`CAD_EV_FOUND],
                event_flags[`CAD_EV_DONE],
                event_flags[`CAD_EV_HOP],
                event_flags[`CAD_EV_RXTO],
                event_flags[`CAD_EV_RECEIVE_FINISHED]};
assign map01 = {clock_output_i,
                synth_lock_i,
                event_flags[`CAD_EV_HDR],
                event_flags[`CAD_EV_HOP],
                event_flags[`CAD_EV_HOP],
                event_flags[`CAD_EV_TRANSMIT_FINISHED]};
assign map10 = {clock_output_i,
                synth_lock_i,
                event_flags[`CAD_EV_CRC],
                event_flags[`CAD_EV_HOP],
                event_flags[`CAD_EV_FOUND],
                event_flags[`CAD_EV_DONE]};

cad_pinmux u_pinmux (
    .sel_i   ({pin_sel_b, pin_sel_a}),
    .map00_i (map00),
    .map01_i (map01),
    .map10_i (map10),
    .pin_o   (pin_lvl)
);

// Registered pins: one cycle behind the flags, glitch free
always @(posedge ref_clk_i) begin
    if (!rst_b_i)
        mpin_o <= 6'h00;
    else
        mpin_o <= pin_lvl;
end

endmodule // cad_top

// [verif/cad_chk.sv]
// Concurrent checks on the scan sequencer ports of the top module
`timescale 1ns/10ps
module cad_chk (
    // Clock and reset
    input wire       ref_clk_i,
    input wire       rst_b_i,
    // Radio side
    input wire       synth_lock_i,
    input wire       synth_en_o,
    input wire       rx_en_o,
    input wire       corr_run_o,
    input wire [2:0] op_mode_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);

    // ==========================================================
    // Phase length counters, restarted while the synthesizer locks
    reg [31:0] cap_n;
    reg [31:0] cor_n;
    always @(posedge ref_clk_i) begin
        if (!rst_b_i || (synth_en_o && !rx_en_o)) begin
            cap_n <= 32'h0;
            cor_n <= 32'h0;
        end else begin
            cap_n <= cap_n + {31'h0, rx_en_o};
            cor_n <= cor_n + {31'h0, corr_run_o};
        end
    end

    // ==========================================================
    // Assertions
    a_rx_needs_synth: assert property (rx_en_o |-> synth_en_o &&
        op_mode_o == 3'h3) else $error("receiver on outside a scan");
    a_synth_first: assert property ($rose(synth_en_o) |->
        !rx_en_o && !corr_run_o) else $error("synthesizer not first");
    a_lock_first: assert property ($rose(rx_en_o) |->
        $past(synth_lock_i)) else $error("capture before lock");
    a_corr_quiet: assert property (corr_run_o |->
        !rx_en_o && !synth_en_o) else $error("radio on in correlation");
    a_corr_after_cap: assert property ($rose(corr_run_o) |->
        $past(rx_en_o)) else $error("correlation without capture");
    a_corr_shorter: assert property (corr_run_o |->
        cor_n + 32'd32 < cap_n) else $error("correlation too long");
    a_mode_returns: assert property (corr_run_o ##1
        (!corr_run_o && op_mode_o == 3'h3) |-> ##1 op_mode_o == 3'h0)
        else $error("no return to standby");
    a_radio_idle: assert property (op_mode_o != 3'h3 |->
        !synth_en_o && !rx_en_o && !corr_run_o)
        else $error("radio active outside scan");
endmodule // cad_chk

// [verif/cad_radio_model.sv]
// Behavioural synthesizer and correlator facing the scan sequencer
`timescale 1ns/10ps
module cad_radio_model (
    // Clock and reset
    input  wire       ref_clk_i,
    input  wire       rst_b_i,
    // Sequencer side
    input  wire       synth_en_i,
    input  wire       corr_run_i,
    output reg        synth_lock_o,
    output reg        corr_hit_o,
    // Bench control
    input  wire       hit_i,
    input  wire [2:0] lock_dly_i
);
    reg [2:0] cnt;
    // Lock drops as soon as the synthesizer is switched off
    always @(posedge ref_clk_i) begin
        if (!rst_b_i || !synth_en_i) begin
            cnt          <= 3'h0;
            synth_lock_o <= 1'b0;
        end else if (cnt == lock_dly_i) begin
            synth_lock_o <= 1'b1;
        end else begin
            cnt <= cnt + 3'h1;
        end
    end
    // Result is meaningless outside correlation, so it toggles there
    always @(posedge ref_clk_i) begin
        if (!rst_b_i)
            corr_hit_o <= 1'b0;
        else
            corr_hit_o <= corr_run_i ? hit_i : ~corr_hit_o;
    end
endmodule // cad_radio_model

// [verif/test_cad_top.sv]
// Self-checking bench for the scan, event flag and pin mapping block
`timescale 1ns/10ps
`include "cad_defines.vh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
    $display("unexpected %0t: got %h want %h", $time, g, e); end end
module test_cad_top;
    reg         ref_clk_i, rst_b_i, avs_read_i, avs_write_i;
    reg  [7:0]  avs_address_i;
    reg  [31:0] avs_writedata_i, d;
    wire [31:0] avs_readdata_o;
    wire        avs_waitrequest_o, synth_lock_i, corr_hit_i, irq_o;
    wire        synth_en_o, rx_en_o, corr_run_o;
    wire [2:0]  op_mode_o;
    wire [5:0]  mpin_o;
    reg  [5:0]  ev, m;
    reg  [1:0]  lv;
    reg         pre, dem, hit_q;
    reg  [2:0]  dly;
    reg  [15:0] bw;
    integer     mismatches, checked, i;
    integer     cap_n = 0;
    integer     cor_n = 0;

    cad_top dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o),
        .synth_lock_i(synth_lock_i), .corr_hit_i(corr_hit_i),
        .synth_en_o(synth_en_o), .rx_en_o(rx_en_o),
        .corr_run_o(corr_run_o), .op_mode_o(op_mode_o),
        .rx_done_i(ev[0]), .rx_timeout_i(ev[1]), .crc_fail_i(ev[2]),
        .header_ok_i(ev[3]), .tx_done_i(ev[4]), .hop_req_i(ev[5]),
        .mode_settled_i(lv[0]), .clock_output_i(lv[1]),
        .preamble_seen_i(pre), .demod_lock_i(dem),
        .mpin_o(mpin_o), .irq_o(irq_o));
    cad_radio_model u_radio (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
        .synth_en_i(synth_en_o), .corr_run_i(corr_run_o),
        .synth_lock_o(synth_lock_i), .corr_hit_o(corr_hit_i),
        .hit_i(hit_q), .lock_dly_i(dly));

    // ==========================================================
    // Clock and phase length monitor
    initial begin
        ref_clk_i = 1'b0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) begin
        if (rx_en_o) cap_n++;
        if (corr_run_o) cor_n++;
    end

    // ==========================================================
    // Bus tasks and expectations
    task final_report;
        begin
            $display("checked %0d mismatches %0d", checked, mismatches);
            if (mismatches == 0 && checked > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    task bus(input w, input [7:0] a, input [31:0] wd);
        integer n;
        begin
            @(posedge ref_clk_i);
            avs_address_i <= a;
            avs_writedata_i <= wd;
            avs_write_i <= w;
            avs_read_i <= !w;
            n = 0;
            @(posedge ref_clk_i);
            while (avs_waitrequest_o !== 1'b0 && n < 50) begin
                @(posedge ref_clk_i);
                n++;
            end
            d = avs_readdata_o;
            avs_write_i <= 1'b0;
            avs_read_i <= 1'b0;
            if (n >= 50) begin
                mismatches++;
                final_report;
            end
        end
    endtask
    task rdc(input [7:0] a, input [31:0] e);
        begin
            bus(1'b0, a, 32'h0);
            `CHK(d, e)
        end
    endtask
    function [5:0] exp_pins(input [1:0] c, input [7:0] f, input s, k, l);
        case (c)
            2'h0: exp_pins = {s, f[0], f[2], f[1], f[7], f[6]};
            2'h1: exp_pins = {k, l, f[4], f[1], f[1], f[3]};
            2'h2: exp_pins = {k, l, f[5], f[1], f[0], f[2]};
            default: exp_pins = 6'h00;
        endcase
    endfunction

    // ==========================================================
    // One scan, then every pin code over the resulting flags
    task scan(input hit, input [7:0] msk);
        integer n, c;
        reg [7:0] f;
        begin
            bw = 16'h1 + ($urandom % 4);
            dly <= $urandom;
            hit_q <= hit;
            bus(1'b1, `CAD_OFF_IRQ_MASK, {24'h0, msk});
            bus(1'b1, `CAD_OFF_CFG, {8'h00, bw, 8'h06});
            cap_n = 0;
            cor_n = 0;
            bus(1'b1, `CAD_OFF_MODE, 32'h3);
            // Mode register takes the write on this edge; look from the next
            @(posedge ref_clk_i);
            n = 0;
            while (op_mode_o !== 3'h0 && n < 4000) begin
                @(posedge ref_clk_i);
                n++;
            end
            `CHK(n < 4000, 1'b1)
            if (n >= 4000)
                final_report;
            `CHK(cap_n, 96 * bw)
            `CHK(cor_n, 56 * bw)
            f = hit ? 8'h05 : 8'h04;
            repeat (2) @(posedge ref_clk_i);
            `CHK(irq_o, |(msk & f))
            `CHK(mpin_o[4], hit)
            `CHK(mpin_o[3], 1'b1)
            rdc(`CAD_OFF_IRQ_STAT, {24'h0, f});
            @(posedge ref_clk_i);
            `CHK(irq_o, 1'b0)
            rdc(`CAD_OFF_SCAN, 32'h0);
            m = $urandom;
            ev <= m;
            lv <= $urandom;
            @(posedge ref_clk_i);
            ev <= 6'h00;
            f = f | {m[1], m[0], m[2], m[3], m[4], 1'b0, m[5], 1'b0};
            // Ends on code 00 so the next scan sees the reset mapping
            for (c = 3; c >= 0; c--) begin
                bus(1'b1, `CAD_OFF_PIN_A, {24'h0, {4{c[1:0]}}});
                bus(1'b1, `CAD_OFF_PIN_B, {28'h0, {2{c[1:0]}}});
                repeat (2) @(posedge ref_clk_i);
                m = exp_pins(c[1:0], f, lv[0], lv[1], synth_lock_i);
                `CHK(mpin_o, m)
            end
            rdc(`CAD_OFF_EVENT, {24'h0, f});
            bus(1'b1, `CAD_OFF_EVENT, 32'hff);
            repeat (2) @(posedge ref_clk_i);
            `CHK(mpin_o, {lv[0], 5'h00})
            bus(1'b1, `CAD_OFF_MODE, 32'h1);
            bus(1'b1, `CAD_OFF_MODE, 32'h0);
            bus(1'b0, `CAD_OFF_IRQ_STAT, 32'h0);
        end
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        {rst_b_i, avs_read_i, avs_write_i, ev, lv, pre, dem, hit_q} = 0;
        {avs_address_i, avs_writedata_i, dly} = 0;
        mismatches = 0;
        checked = 0;
        d = $urandom(9436);
        repeat (4) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        rdc(8'h24, 32'h0);
        pre <= 1'b1;
        rdc(`CAD_OFF_MODEM, 32'h1);
        dem <= 1'b1;
        rdc(`CAD_OFF_MODEM, 32'h3);
        ev <= 6'h08;
        @(posedge ref_clk_i);
        ev <= 6'h00;
        rdc(`CAD_OFF_MODEM, 32'hb);
        pre <= 1'b0;
        dem <= 1'b0;
        bus(1'b1, `CAD_OFF_EVENT, 32'hff);
        bus(1'b0, `CAD_OFF_IRQ_STAT, 32'h0);
        for (i = 0; i < 4; i++)
            scan(i[0], (i < 2) ? 8'h05 : 8'h00);
        // Corner: a mode write during capture aborts without any flag
        bus(1'b1, `CAD_OFF_MODE, 32'h3);
        i = 0;
        while (rx_en_o !== 1'b1 && i < 50) begin
            @(posedge ref_clk_i);
            i++;
        end
        `CHK(rx_en_o, 1'b1)
        if (i >= 50)
            final_report;
        bus(1'b1, `CAD_OFF_MODE, 32'h0);
        rdc(`CAD_OFF_SCAN, 32'h0);
        rdc(`CAD_OFF_MODE, 32'h0);
        rdc(`CAD_OFF_EVENT, 32'h0);
        final_report;
    end
endmodule // test_cad_top

bind cad_top cad_chk u_chk (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .synth_lock_i(synth_lock_i), .synth_en_o(synth_en_o),
    .rx_en_o(rx_en_o), .corr_run_o(corr_run_o), .op_mode_o(op_mode_o));
